//--- rtl/wm_modulator.sv
// What this block does
// - offers AM, FM, PM and amplitude keying on the carrier when enabled
// - carrier may be sine, square or ramp only; sine by default
// - sine carrier accepts one microhertz to one gigahertz
// - six modulating shapes: sine, square, triangle, rising, falling ramp, noise
// - noise is Gaussian and only a modulating shape, never carrier
// - modulating rate 2 mHz to 1 MHz, 1 uHz steps, default 100 Hz
// - AM scales carrier amplitude by instantaneous modulating value
// - AM depth 0 to 120 percent in 0.001 percent steps, default 100
// - zero depth gives half the configured carrier amplitude
// - full depth peaks at the configured carrier amplitude
// - carrier suppression leaves only sidebands; off after reset
// - FM shifts frequency proportional to modulating value, up to deviation
// - frequency deviation is at least one microhertz
// - deviation above carrier frequency is clamped to carrier frequency
// - reject carrier plus deviation above shape maximum plus 1 kHz
// - PM offsets carrier phase by modulating value, up to phase deviation
// - phase deviation 0 to 360 degrees, 0.001 degree steps, default 90
// - keying uses a half-duty square to pick carrier or keyed amplitude
// - keying rate 2 mHz to 1 MHz, default 100 Hz
// - keyed amplitude 25 mV to 1 V, 10 uV steps, default 700 mV
//
// Chosen here: the placing of the registers and register access over Avalon-MM.
`default_nettype none
module wm_modulator
    import wm_pkg::*;
#(
    parameter int ACC_W = 48
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [15:0] sample_data,
    output logic sample_valid
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // merge write data into a word under byte enables
    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // rate in uHz to accumulator step at the 10 MHz clock
    function automatic logic [ACC_W-1:0] freq_to_inc(input logic [49:0] f);
        logic [70:0] p;
        p = 71'(f) * 71'(WM_INC_SCALE);
        return p[ACC_W+15:16];
    endfunction

    // parabolic sine from a 16-bit phase; cheap, about 4 % harmonic error
    function automatic logic signed [15:0] sine_of(input logic [15:0] ph);
        logic [29:0] y;
        logic [15:0] mag;
        y = 30'(ph[14:0]) * (30'h8000 - 30'(ph[14:0]));
        mag = (y[29:13] > 17'h07FFF) ? 16'h7FFF : y[28:13];
        return ph[15] ? -$signed(mag) : $signed(mag);
    endfunction

    // unsigned value times a Q16 factor, kept at Q16
    function automatic logic [17:0] to_q16(input logic [18:0] v, input logic [15:0] k);
        logic [34:0] p;
        p = 35'(v) * 35'(k);
        return p[33:16];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // reset release through two flops

    logic [1:0] rst_sync_reg;
    logic rst_n;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    ////////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle on every access

    logic ack_reg;
    logic wr_go;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
        end
    end
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign wr_go = avs_write & ack_reg;

    // settings
    wm_type_e type_reg;
    wm_car_e car_reg;
    wm_shape_e shape_reg;
    logic supp_reg;
    logic en_reg;
    logic [49:0] car_freq_reg;
    logic [39:0] mod_freq_reg;
    logic [49:0] dev_reg;
    logic [16:0] depth_reg;
    logic [18:0] pdev_reg;
    logic [16:0] car_ampl_reg;
    logic [16:0] key_ampl_reg;
    logic reject_reg;
    logic [31:0] cur_word;
    logic [31:0] new_word;
    logic bad_write;
    logic [49:0] dev_eff;
    logic dev_clamped;
    logic cfg_err;

    // word as it stands now, shared by readback and write merge
    always_comb begin
        cur_word = 32'h0;
        unique case (avs_address)
            WM_CTRL_OFS: begin
                cur_word[WM_CTRL_TYPE_LSB +: 2] = type_reg;
                cur_word[WM_CTRL_CAR_LSB +: 3] = car_reg;
                cur_word[WM_CTRL_SHAPE_LSB +: 3] = shape_reg;
                cur_word[WM_CTRL_SUPP_BIT] = supp_reg;
                cur_word[WM_CTRL_EN_BIT] = en_reg;
            end
            WM_STATUS_OFS: cur_word[2:0] = {dev_clamped, cfg_err, reject_reg};
            WM_CAR_FREQ_LO_OFS: cur_word = car_freq_reg[31:0];
            WM_CAR_FREQ_HI_OFS: cur_word[17:0] = car_freq_reg[49:32];
            WM_MOD_FREQ_LO_OFS: cur_word = mod_freq_reg[31:0];
            WM_MOD_FREQ_HI_OFS: cur_word[7:0] = mod_freq_reg[39:32];
            WM_DEPTH_OFS: cur_word[16:0] = depth_reg;
            WM_DEV_LO_OFS: cur_word = dev_eff[31:0];
            WM_DEV_HI_OFS: cur_word[17:0] = dev_eff[49:32];
            WM_PHASE_DEV_OFS: cur_word[18:0] = pdev_reg;
            WM_CAR_AMPL_OFS: cur_word[16:0] = car_ampl_reg;
            WM_KEY_AMPL_OFS: cur_word[16:0] = key_ampl_reg;
            default: cur_word = 32'h0;
        endcase
    end
    assign new_word = be_merge(cur_word, avs_writedata, avs_byteenable);

    // read data loaded in the wait cycle, stands at the answering edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0;
        end else if (avs_read & ~ack_reg) begin
            avs_readdata <= cur_word;
        end
    end

    // out-of-range single-word writes leave the old value in place
    always_comb begin
        bad_write = 1'b0;
        unique case (avs_address)
            WM_CTRL_OFS: bad_write = (new_word[WM_CTRL_CAR_LSB +: 3] > 3'h2) ||
                                     (new_word[WM_CTRL_SHAPE_LSB +: 3] > 3'h5);
            WM_DEPTH_OFS: bad_write = new_word[16:0] > WM_DEPTH_MAX;
            WM_PHASE_DEV_OFS: bad_write = new_word[18:0] > WM_PDEV_MAX;
            WM_KEY_AMPL_OFS: bad_write = (new_word[16:0] < WM_AMPL_MIN) ||
                                         (new_word[16:0] > WM_AMPL_MAX);
            WM_CAR_AMPL_OFS: bad_write = (new_word[16:0] < WM_AMPL_MIN) ||
                                         (new_word[16:0] > WM_AMPL_MAX);
            default: bad_write = 1'b0;
        endcase
    end

    // register writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            type_reg <= WM_AM;
            car_reg <= WM_CAR_SINE;
            shape_reg <= WM_SH_SINE;
            supp_reg <= 1'b0;
            en_reg <= 1'b0;
            car_freq_reg <= WM_CAR_RST_UHZ;
            mod_freq_reg <= WM_MOD_RST_UHZ;
            dev_reg <= WM_DEV_RST_UHZ;
            depth_reg <= WM_DEPTH_RST;
            pdev_reg <= WM_PDEV_RST;
            car_ampl_reg <= WM_CAR_AMPL_RST;
            key_ampl_reg <= WM_KEY_AMPL_RST;
        end else if (wr_go && !bad_write) begin
            unique case (avs_address)
                WM_CTRL_OFS: begin
                    type_reg <= wm_type_e'(new_word[WM_CTRL_TYPE_LSB +: 2]);
                    car_reg <= wm_car_e'(new_word[WM_CTRL_CAR_LSB +: 3]);
                    shape_reg <= wm_shape_e'(new_word[WM_CTRL_SHAPE_LSB +: 3]);
                    supp_reg <= new_word[WM_CTRL_SUPP_BIT];
                    en_reg <= new_word[WM_CTRL_EN_BIT];
                end
                WM_CAR_FREQ_LO_OFS: car_freq_reg[31:0] <= new_word;
                WM_CAR_FREQ_HI_OFS: car_freq_reg[49:32] <= new_word[17:0];
                WM_MOD_FREQ_LO_OFS: mod_freq_reg[31:0] <= new_word;
                WM_MOD_FREQ_HI_OFS: mod_freq_reg[39:32] <= new_word[7:0];
                WM_DEPTH_OFS: depth_reg <= new_word[16:0];
                WM_DEV_LO_OFS: dev_reg[31:0] <= new_word;
                WM_DEV_HI_OFS: dev_reg[49:32] <= new_word[17:0];
                WM_PHASE_DEV_OFS: pdev_reg <= new_word[18:0];
                WM_CAR_AMPL_OFS: car_ampl_reg <= new_word[16:0];
                WM_KEY_AMPL_OFS: key_ampl_reg <= new_word[16:0];
                default: ;
            endcase
        end
    end

    // sticky reject flag, write 1 to status bit 0 clears; a new reject wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reject_reg <= 1'b0;
        end else if (wr_go && bad_write) begin
            reject_reg <= 1'b1;
        end else if (wr_go && avs_address == WM_STATUS_OFS && avs_writedata[0]) begin
            reject_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration checks that span several words

    logic [49:0] car_max;
    logic [50:0] freq_sum;

    // clamp deviation to carrier, never below one microhertz
    always_comb begin
        dev_clamped = dev_reg > car_freq_reg;
        dev_eff = dev_clamped ? car_freq_reg : dev_reg;
        if (dev_eff == 50'h0) begin
            dev_eff = 50'h1;
        end
    end

    // shape ceiling and combined frequency test
    always_comb begin
        unique case (car_reg)
            WM_CAR_SQUARE: car_max = WM_SQUARE_MAX_UHZ;
            WM_CAR_RAMP: car_max = WM_RAMP_MAX_UHZ;
            default: car_max = WM_SINE_MAX_UHZ;
        endcase
        freq_sum = 51'(car_freq_reg) + 51'(dev_eff);
        cfg_err = (car_freq_reg == 50'h0) || (car_freq_reg > car_max) ||
                  (mod_freq_reg < WM_MOD_MIN_UHZ) || (mod_freq_reg > WM_MOD_MAX_UHZ) ||
                  ((type_reg == WM_FM) &&
                   (freq_sum > 51'(car_max) + 51'(WM_DEV_MARGIN_UHZ)));
    end

    ////////////////////////////////////////////////////////////////////////////
    // modulating source

    logic [ACC_W-1:0] mod_acc_reg;
    logic [47:0] lfsr_reg;
    logic signed [15:0] mod_val_reg;
    logic signed [15:0] mod_val_next;
    logic [15:0] mph;
    logic [13:0] noise_sum;

    // phase accumulator stepped by the rate; also the keying square
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mod_acc_reg <= '0;
        end else begin
            mod_acc_reg <= mod_acc_reg + freq_to_inc(50'(mod_freq_reg));
        end
    end

    // noise generator, advances every clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lfsr_reg <= WM_LFSR_SEED;
        end else begin
            lfsr_reg <= (lfsr_reg >> 1) ^ (lfsr_reg[0] ? WM_LFSR_TAPS : 48'h0);
        end
    end

    // shape select; four uniform draws summed approach a gaussian
    always_comb begin
        mph = mod_acc_reg[ACC_W-1 -: 16];
        noise_sum = 14'(lfsr_reg[11:0]) + 14'(lfsr_reg[23:12]) +
                    14'(lfsr_reg[35:24]) + 14'(lfsr_reg[47:36]);
        unique case (shape_reg)
            WM_SH_SQUARE: mod_val_next = mph[15] ? -16'sh7FFF : 16'sh7FFF;
            WM_SH_TRIANGLE: mod_val_next = mph[15] ? $signed(16'h7FFF - {mph[14:0], 1'b0})
                                                   : $signed({mph[14:0], 1'b0} - 16'h7FFF);
            WM_SH_RISING_RAMP: mod_val_next = $signed(mph ^ 16'h8000);
            WM_SH_FALLING_RAMP: mod_val_next = $signed(~mph ^ 16'h8000);
            WM_SH_NOISE: mod_val_next = $signed(16'({2'h0, noise_sum} - 16'h1FFE) << 2);
            default: mod_val_next = sine_of(mph);
        endcase
        if (type_reg == WM_ASK) begin
            mod_val_next = mph[15] ? -16'sh7FFF : 16'sh7FFF;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mod_val_reg <= 16'sh0;
        end else begin
            mod_val_reg <= mod_val_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // carrier oscillator with frequency and phase modulation

    logic [ACC_W-1:0] car_acc_reg;
    logic signed [64:0] fm_prod;
    logic signed [ACC_W-1:0] fm_step;
    logic [17:0] pdev_q16;
    logic signed [34:0] pm_prod;
    logic [15:0] cph;
    logic signed [15:0] car_val_reg;
    logic signed [15:0] car_val_next;

    // frequency offset proportional to the modulating value
    always_comb begin
        fm_prod = $signed({1'b0, freq_to_inc(dev_eff)}) * 65'(mod_val_reg);
        fm_step = (type_reg == WM_FM) ? fm_prod[ACC_W+14:15] : '0;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            car_acc_reg <= '0;
        end else begin
            car_acc_reg <= car_acc_reg + freq_to_inc(car_freq_reg) + fm_step;
        end
    end

    // phase offset: deviation turned into a fraction of a turn
    always_comb begin
        pdev_q16 = to_q16(pdev_reg, WM_Q16_PER_MILLIDEG);
        pm_prod = $signed({1'b0, 17'(pdev_q16)}) * 35'(mod_val_reg);
        cph = car_acc_reg[ACC_W-1 -: 16];
        if (type_reg == WM_PM) begin
            cph = cph + pm_prod[30:15];
        end
        unique case (car_reg)
            WM_CAR_SQUARE: car_val_next = cph[15] ? -16'sh7FFF : 16'sh7FFF;
            WM_CAR_RAMP: car_val_next = $signed(cph ^ 16'h8000);
            default: car_val_next = sine_of(cph);
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            car_val_reg <= 16'sh0;
        end else begin
            car_val_reg <= car_val_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // amplitude path

    logic [17:0] depth_q16;
    logic signed [34:0] dm_prod;
    logic signed [18:0] dm;
    logic signed [18:0] env_next;
    logic signed [18:0] env_reg;
    logic [17:0] amp_next;
    logic [17:0] amp_reg;

    // envelope in Q16: half plus half depth times value, or sidebands only
    always_comb begin
        depth_q16 = to_q16({2'h0, depth_reg}, WM_Q16_PER_MILLIPCT);
        dm_prod = $signed({1'b0, 17'(depth_q16)}) * 35'(mod_val_reg);
        dm = dm_prod[33:15];
        if (type_reg != WM_AM) begin
            env_next = 19'sh10000;
        end else if (supp_reg) begin
            env_next = dm;
        end else begin
            env_next = (19'sh10000 + dm) >>> 1;
        end
        if (type_reg == WM_ASK && mod_val_reg[15]) begin
            amp_next = to_q16({2'h0, key_ampl_reg}, WM_Q16_PER_MILLIPCT);
        end else begin
            amp_next = to_q16({2'h0, car_ampl_reg}, WM_Q16_PER_MILLIPCT);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            env_reg <= 19'sh0;
            amp_reg <= 18'h0;
        end else begin
            env_reg <= env_next;
            amp_reg <= amp_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mixer and output

    logic signed [34:0] mix_prod;
    logic signed [18:0] mix_reg;
    logic signed [37:0] out_prod;
    logic signed [21:0] out_val;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mix_reg <= 19'sh0;
        end else begin
            mix_reg <= mix_prod[34:16];
        end
    end
    assign mix_prod = 35'(car_val_reg) * 35'(env_reg);

    // overmodulation can pass full scale, so saturate
    assign out_prod = 38'(mix_reg) * $signed({20'h0, amp_reg});
    assign out_val = out_prod[37:16];

    // muted and not valid while off or the setup is rejected
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_data <= 16'h0;
            sample_valid <= 1'b0;
        end else if (!en_reg || cfg_err) begin
            sample_data <= 16'h0;
            sample_valid <= 1'b0;
        end else begin
            sample_valid <= 1'b1;
            if (out_val > 22'sh007FFF) begin
                sample_data <= 16'h7FFF;
            end else if (out_val < -22'sh007FFF) begin
                sample_data <= 16'h8001;
            end else begin
                sample_data <= out_val[15:0];
            end
        end
    end

endmodule // wm_modulator
`default_nettype wire

//--- include/wm_pkg.sv
`default_nettype none
package wm_pkg;
    // register byte offsets, one 32-bit word each
    localparam logic [7:0] WM_CTRL_OFS = 8'h00;
    localparam logic [7:0] WM_STATUS_OFS = 8'h04;
    localparam logic [7:0] WM_CAR_FREQ_LO_OFS = 8'h08;
    localparam logic [7:0] WM_CAR_FREQ_HI_OFS = 8'h0C;
    localparam logic [7:0] WM_MOD_FREQ_LO_OFS = 8'h10;
    localparam logic [7:0] WM_MOD_FREQ_HI_OFS = 8'h14;
    localparam logic [7:0] WM_DEPTH_OFS = 8'h18;
    localparam logic [7:0] WM_DEV_LO_OFS = 8'h1C;
    localparam logic [7:0] WM_DEV_HI_OFS = 8'h20;
    localparam logic [7:0] WM_PHASE_DEV_OFS = 8'h24;
    localparam logic [7:0] WM_CAR_AMPL_OFS = 8'h28;
    localparam logic [7:0] WM_KEY_AMPL_OFS = 8'h2C;
    // control field positions
    localparam int WM_CTRL_TYPE_LSB = 0;
    localparam int WM_CTRL_CAR_LSB = 2;
    localparam int WM_CTRL_SHAPE_LSB = 5;
    localparam int WM_CTRL_SUPP_BIT = 8;
    localparam int WM_CTRL_EN_BIT = 9;
    // modulation types, carrier shapes, modulating shapes
    typedef enum logic [1:0] {
        WM_AM = 2'h0, WM_FM = 2'h1, WM_PM = 2'h2, WM_ASK = 2'h3
    } wm_type_e;
    typedef enum logic [2:0] {
        WM_CAR_SINE = 3'h0, WM_CAR_SQUARE = 3'h1, WM_CAR_RAMP = 3'h2,
        WM_CAR_PULSE = 3'h3, WM_CAR_NOISE = 3'h4
    } wm_car_e;
    typedef enum logic [2:0] {
        WM_SH_SINE = 3'h0, WM_SH_SQUARE = 3'h1, WM_SH_TRIANGLE = 3'h2,
        WM_SH_RISING_RAMP = 3'h3, WM_SH_FALLING_RAMP = 3'h4, WM_SH_NOISE = 3'h5
    } wm_shape_e;
    // frequencies in micro-hertz
    localparam logic [49:0] WM_SINE_MAX_UHZ = 50'h38D7EA4C68000;
    localparam logic [49:0] WM_SQUARE_MAX_UHZ = 50'h1C6BF52634000;
    localparam logic [49:0] WM_RAMP_MAX_UHZ = 50'h02D79883D2000;
    localparam logic [49:0] WM_DEV_MARGIN_UHZ = 50'h0003B9ACA00;
    localparam logic [39:0] WM_MOD_MIN_UHZ = 40'h00000007D0;
    localparam logic [39:0] WM_MOD_MAX_UHZ = 40'hE8D4A51000;
    localparam logic [39:0] WM_MOD_RST_UHZ = 40'h0005F5E100;
    localparam logic [49:0] WM_CAR_RST_UHZ = 50'h00000003B9ACA00;
    localparam logic [49:0] WM_DEV_RST_UHZ = 50'h00000003B9ACA00;
    // depth 0.001 %, phase 0.001 deg, amplitude 10 uV units
    localparam logic [16:0] WM_DEPTH_MAX = 17'h1D4C0;
    localparam logic [16:0] WM_DEPTH_RST = 17'h186A0;
    localparam logic [18:0] WM_PDEV_MAX = 19'h57E40;
    localparam logic [18:0] WM_PDEV_RST = 19'h15F90;
    localparam logic [16:0] WM_AMPL_MIN = 17'h009C4;
    localparam logic [16:0] WM_AMPL_MAX = 17'h186A0;
    localparam logic [16:0] WM_KEY_AMPL_RST = 17'h11170;
    localparam logic [16:0] WM_CAR_AMPL_RST = 17'h0C350;
    // scale factors: rate-to-increment and unit-to-Q16 multipliers; noise LFSR taps and seed
    localparam logic [20:0] WM_INC_SCALE = 21'h1C25C2;
    localparam logic [15:0] WM_Q16_PER_MILLIPCT = 16'hA7C6;
    localparam logic [15:0] WM_Q16_PER_MILLIDEG = 16'h2E9A;
    localparam logic [47:0] WM_LFSR_TAPS = 48'hC00000180000;
    localparam logic [47:0] WM_LFSR_SEED = 48'h000000000001;
endpackage
`default_nettype wire

//--- tb/wm_modulator_assertions.sv
`default_nettype none
module wm_chk
    import wm_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [15:0] sample_data,
    input wire logic sample_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic req;
    logic off;
    // legal control write clearing enable; a rejected one would keep it on
    assign req = avs_read | avs_write;
    assign off = avs_write & ~avs_waitrequest & (avs_address == WM_CTRL_OFS)
        & (avs_byteenable == 4'hF) & ~avs_writedata[WM_CTRL_EN_BIT]
        & (avs_writedata[4:2] < 3'h3) & (avs_writedata[7:5] < 3'h6);
    ////////////////////////////////////////////////////////////////////////
    property p_wfirst; $rose(req) |-> avs_waitrequest; endproperty
    a_wfirst: assert property (p_wfirst) else $error("no wait state");
    property p_wone; req && avs_waitrequest |=> !avs_waitrequest; endproperty
    a_wone: assert property (p_wone) else $error("wait longer than one");
    property p_widle; !req |-> !avs_waitrequest; endproperty
    a_widle: assert property (p_widle) else $error("wait without request");
    property p_rhold; !(avs_read && avs_waitrequest) |=> $stable(avs_readdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read data moved");
    property p_unmap; avs_read && !avs_waitrequest && avs_address > WM_KEY_AMPL_OFS
        |-> avs_readdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_mute; !sample_valid |-> sample_data == 16'h0000; endproperty
    a_mute: assert property (p_mute) else $error("muted sample not zero");
    property p_off; off |-> ##[1:6] !sample_valid; endproperty
    a_off: assert property (p_off) else $error("stream not stopped");
    property p_fs; sample_valid |-> sample_data != 16'h8000; endproperty
    a_fs: assert property (p_fs) else $error("sample beyond full scale");
    cover property (req && !avs_waitrequest);
    cover property ($rose(sample_valid));
    cover property ($fell(sample_valid));
endmodule // wm_chk
bind wm_modulator wm_chk chk_u (.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sample_data(sample_data),
    .sample_valid(sample_valid));
`default_nettype wire

//--- tb/test_waveform_modulator.sv
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_waveform_modulator
    import wm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] adr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0] be = 4'hF;
    logic [31:0] rdat;
    logic wrq;
    logic [15:0] sd;
    logic sv;
    logic wrq_s;
    logic [31:0] rv;
    logic [15:0] pk;
    int fails = 0;
    int checks = 0;
    // offset, rejected value, value kept, top accepted value
    int lim [3][4] = '{'{WM_DEPTH_OFS, WM_DEPTH_MAX + 1, WM_DEPTH_RST, WM_DEPTH_MAX},
        '{WM_PHASE_DEV_OFS, WM_PDEV_MAX + 1, WM_PDEV_RST, WM_PDEV_MAX},
        '{WM_KEY_AMPL_OFS, WM_AMPL_MIN - 1, WM_KEY_AMPL_RST, WM_AMPL_MAX}};
    // control, depth, carrier amplitude, peak low and high bound
    int cs [4][5] = '{'{'h224, 0, 'h186A0, 'h3F5C, 'h40A6},
        '{'h224, 'h186A0, 'h186A0, 'h7E90, 'h7FFF}, '{'h324, 0, 'h186A0, 0, 0},
        '{'h227, 'h186A0, 'h61A8, 'h7E90, 'h7FFF}};
    wm_modulator dut_u (.clk(clk), .arst_n(arst_n), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
        .avs_waitrequest(wrq), .sample_data(sd), .sample_valid(sv));
    // 10 MHz clock
    always #50 clk = ~clk;
    // mid-cycle copy of waitrequest, equal to what the next rising edge sees
    always @(negedge clk) wrq_s = wrq;
    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (fails == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one bus cycle, held until waitrequest is seen low
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (wrq_s !== 1'b0 && n < 50);
        if (n >= 50) fails++;
        rv = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask
    task automatic r(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        `CHK(rv, e)
    endtask
    // let a setting settle, then look at the stream flag
    task automatic sk(input logic e);
        repeat (8) @(negedge clk);
        `CHK(sv, e)
    endtask
    // largest magnitude over one and a half 10 kHz modulating periods
    task automatic peak;
        logic [15:0] m;
        pk = 16'h0000;
        repeat (1500) begin
            @(negedge clk);
            m = sd[15] ? 16'h0000 - sd : sd;
            if (sv === 1'b1 && m > pk) pk = m;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // watchdog, several times the expected run length
    initial begin
        #3000000;
        fails++;
        end_sim();
    end
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        r(WM_CTRL_OFS, 32'h0);
        r(WM_MOD_FREQ_LO_OFS, WM_MOD_RST_UHZ[31:0]);
        w(8'h30, 32'hFFFFFFFF);
        r(8'h30, 32'h0);
        foreach (lim[i]) begin
            w(8'(lim[i][0]), 32'(lim[i][1]));
            r(8'(lim[i][0]), 32'(lim[i][2]));
            w(8'(lim[i][0]), 32'(lim[i][3]));
            r(8'(lim[i][0]), 32'(lim[i][3]));
        end
        w(WM_STATUS_OFS, 32'h1);
        // carriers 3..7 and shapes 6..7 are all refused
        for (int c = 3; c < 10; c++) begin
            w(WM_CTRL_OFS, c < 8 ? 32'(c) << 2 : 32'(c - 2) << 5);
            r(WM_CTRL_OFS, 32'h0);
            r(WM_STATUS_OFS, 32'h1);
            w(WM_STATUS_OFS, 32'h1);
        end
        for (int i = 0; i < 6; i++) begin
            w(WM_CTRL_OFS, 32'h200 | 32'(i % 4) | 32'(i) << 5);
            sk(1'b1);
        end
        w(WM_CTRL_OFS, 32'h201);
        w(WM_DEV_LO_OFS, 32'h77359400);
        r(WM_DEV_LO_OFS, WM_CAR_RST_UHZ[31:0]);
        r(WM_STATUS_OFS, 32'h4);
        w(WM_CTRL_OFS, 32'h001);
        w(WM_CAR_FREQ_LO_OFS, WM_SINE_MAX_UHZ[31:0]);
        w(WM_CAR_FREQ_HI_OFS, 32'(WM_SINE_MAX_UHZ[49:32]));
        w(WM_DEV_LO_OFS, WM_DEV_MARGIN_UHZ[31:0]);
        w(WM_CTRL_OFS, 32'h201);
        sk(1'b1);
        w(WM_DEV_LO_OFS, WM_DEV_MARGIN_UHZ[31:0] + 32'h1);
        sk(1'b0);
        r(WM_STATUS_OFS, 32'h2);
        w(WM_DEV_LO_OFS, 32'h0);
        r(WM_DEV_LO_OFS, 32'h1);
        // 100 kHz sine carrier, modulating rate at its lower edge
        w(WM_CTRL_OFS, 32'h000);
        w(WM_CAR_FREQ_LO_OFS, 32'h4876E800);
        w(WM_CAR_FREQ_HI_OFS, 32'h17);
        w(WM_MOD_FREQ_LO_OFS, 32'(WM_MOD_MIN_UHZ) - 32'h1);
        w(WM_CTRL_OFS, 32'h200);
        sk(1'b0);
        w(WM_MOD_FREQ_LO_OFS, 32'(WM_MOD_MIN_UHZ));
        sk(1'b1);
        w(WM_MOD_FREQ_LO_OFS, 32'h540BE400);
        w(WM_MOD_FREQ_HI_OFS, 32'h2);
        foreach (cs[i]) begin
            w(WM_DEPTH_OFS, 32'(cs[i][1]));
            w(WM_CAR_AMPL_OFS, 32'(cs[i][2]));
            w(WM_CTRL_OFS, 32'(cs[i][0]));
            sk(1'b1);
            peak();
            `CHK(pk >= 16'(cs[i][3]) && pk <= 16'(cs[i][4]), 1'b1)
        end
        end_sim();
    end
endmodule // test_waveform_modulator
`default_nettype wire
